// ===== rtl/rsfp_defines.svh
/*
  Register offsets, field positions, reset values and fixed figures of the
  reset-state and floating-point enable block.
  Assumes byte addresses on an 8-bit classic Wishbone address, one 32-bit word
  per register.
*/
`ifndef RSFP_DEFINES_SVH
`define RSFP_DEFINES_SVH

`define RSFP_ADR_ID          8'h00
`define RSFP_ADR_CTRL        8'h04
`define RSFP_ADR_MT_DEF      8'h08
`define RSFP_ADR_EXT_FEAT    8'h0c
`define RSFP_ADR_FP_CW       8'h20
`define RSFP_ADR_FP_SW       8'h24
`define RSFP_ADR_FP_TW       8'h28
`define RSFP_ADR_WM_CS       8'h2c
`define RSFP_RANGE_BASE_HI   4'h1
`define RSFP_FPDATA_BASE_HI  3'h2
`define RSFP_MEDIA_BASE_HI   3'h3

`define RSFP_CTL_CACHE_OFF   0
`define RSFP_CTL_WAIT_TRAP   1
`define RSFP_CTL_SW_TRAP     2
`define RSFP_CTL_INT_FAULT   3
`define RSFP_CTL_TASK_SW     4
`define RSFP_CTL_WM_OS       5
`define RSFP_CTL_WM_FAULT    6
`define RSFP_CTL_W           7
`define RSFP_CTL_RST         7'h01
`define RSFP_CTL_KEEP_SOFT   7'h01

`define RSFP_MT_DEF_W        12
`define RSFP_MT_DEF_RST      12'h000
`define RSFP_MT_DEF_EN       11

`define RSFP_EXT_FASTCALL    0

`define RSFP_FP_CW_RST       16'h0040
`define RSFP_FP_SW_RST       16'h0000
`define RSFP_FP_TW_RST       16'h5555
`define RSFP_FP_CW_CLEAR     16'h037f
`define RSFP_FP_TW_CLEAR     16'hffff
`define RSFP_WM_CS_RST       16'h1f80
`define RSFP_WM_MASK_LO      7
`define RSFP_WM_MASK_HI      12
`define RSFP_WM_FLAG_W       6

`define RSFP_ID_STEP_LO      0
`define RSFP_ID_MODEL_LO     4
`define RSFP_ID_FAMILY_LO    8
`define RSFP_ID_EXTMOD_LO    16
`define RSFP_ID_EXTFAM_LO    20

`endif

// ===== rtl/rsfp_pkg.sv
/*
  Types shared by the reset-state and floating-point enable block.
  Assumes the defines header is included by files that need the figures.
*/
package rsfp_pkg;

  typedef enum logic [2:0]
  {
    RSFP_OP_X87,
    RSFP_OP_FP_SYNC,
    RSFP_OP_FP_CLEAR,
    RSFP_OP_MEDIA64,
    RSFP_OP_MEDIA128,
    RSFP_OP_FAST_CALL,
    RSFP_OP_MODEL_READ,
    RSFP_OP_MODEL_WRITE
  } rsfp_op_t;

  typedef enum logic [2:0]
  {
    RSFP_FLT_NONE,
    RSFP_FLT_FP_UNAVAIL,
    RSFP_FLT_BAD_OPCODE,
    RSFP_FLT_FP_PENDING,
    RSFP_FLT_SIMD_FP
  } rsfp_fault_t;

endpackage

// ===== rtl/rsfp_reset_ctl.sv
/*
  Reset-state and enable gating: identity word, cache enable, memory-type
  default, x87 and media state reset, and the fault decisions for x87,
  64-bit and 128-bit media and fast-call instructions.
  Assumes a single 10 MHz clock, a synchronous active-low hard reset, a
  synchronous soft-restart pulse, and a classic Wishbone master.
*/
// Implementation choices: the Wishbone slave port and the address map.
`timescale 1ns/1ps
`include "rsfp_defines.svh"

module rsfp_reset_ctl
  import rsfp_pkg::*;
#(
  parameter logic [3:0] STEPPING   = 4'h1,
  parameter logic [3:0] MODEL      = 4'h2,
  parameter logic [3:0] FAMILY     = 4'h3,
  parameter logic [3:0] EXT_MODEL  = 4'h0,
  parameter logic [7:0] EXT_FAMILY = 8'h00
)
(
  input  wire logic                      clk_sys,
  input  wire logic                      nrst,
  input  wire logic                      softRestart,
  input  wire logic                      wbCycI,
  input  wire logic                      wbStbI,
  input  wire logic                      wbWeI,
  input  wire logic [7:0]                wbAdrI,
  input  wire logic [3:0]                wbSelI,
  input  wire logic [31:0]               wbDatI,
  output logic      [31:0]               wbDatO,
  output logic                           wbAckO,
  input  wire logic                      instrValid,
  input  rsfp_op_t                       instrOp,
  input  wire logic [1:0]                instrIdx,
  input  wire logic [31:0]               instrData,
  output logic                           respValid,
  output rsfp_fault_t                    respFault,
  output logic      [31:0]               respData,
  input  wire logic                      x87ExcIn,
  input  wire logic                      simdExcIn,
  input  wire logic [`RSFP_WM_FLAG_W-1:0] simdExcFlags,
  output logic                           excFaultValid,
  output rsfp_fault_t                    excFault,
  output logic                           fpErrorExt,
  output logic      [31:0]               resetIdWord,
  output logic                           cacheEnable,
  output logic                           cacheInvalidate,
  output logic                           memTypeEnable
);

  logic [`RSFP_CTL_W-1:0]    ctrl_r;
  logic [`RSFP_MT_DEF_W-1:0] memDef_r;
  logic                      fastCallEn_r;
  logic [15:0]               fpCw_r;
  logic [15:0]               fpSw_r;
  logic [15:0]               fpTw_r;
  logic [15:0]               wmCs_r;
  logic [15:0]               wmCs_nxt;
  logic [31:0]               fpData_r   [8];
  logic [31:0]               media_r    [8];
  logic [31:0]               memRange_r [4];
  logic [31:0]               modelReg_r [4];
  logic [31:0]               rdData;

  // Byte-lane merge used by every bus-writable register.
  function automatic logic [31:0] mergeSel(input logic [31:0] oldV,
                                           input logic [31:0] newV,
                                           input logic [3:0]  sel);
    logic [31:0] res;
    res = oldV;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        res[8*b +: 8] = newV[8*b +: 8];
    end
    return res;
  endfunction

  // Fault decision for one issued instruction against the enable bits.
  function automatic rsfp_fault_t faultFor(input rsfp_op_t          op,
                                           input logic [`RSFP_CTL_W-1:0] ctl,
                                           input logic              fcEn);
    rsfp_fault_t f;
    f = RSFP_FLT_NONE;
    case (op)
      RSFP_OP_X87, RSFP_OP_FP_CLEAR:
        if (ctl[`RSFP_CTL_SW_TRAP])
          f = RSFP_FLT_FP_UNAVAIL;
      RSFP_OP_FP_SYNC:
        if (ctl[`RSFP_CTL_WAIT_TRAP] && ctl[`RSFP_CTL_TASK_SW])
          f = RSFP_FLT_FP_UNAVAIL;
      RSFP_OP_MEDIA64:
        if (ctl[`RSFP_CTL_SW_TRAP])
          f = RSFP_FLT_BAD_OPCODE;
      RSFP_OP_MEDIA128:
        if (ctl[`RSFP_CTL_SW_TRAP] || !ctl[`RSFP_CTL_WM_OS])
          f = RSFP_FLT_BAD_OPCODE;
      RSFP_OP_FAST_CALL:
        if (!fcEn)
          f = RSFP_FLT_BAD_OPCODE;
      default:
        f = RSFP_FLT_NONE;
    endcase
    return f;
  endfunction

  // Bus decode. The ack term keeps a held request from acting twice.
  wire         busReq    = wbCycI & wbStbI & ~wbAckO;
  wire         busWr     = busReq & wbWeI;
  wire [2:0]   adrIdx8   = wbAdrI[4:2];
  wire [1:0]   adrIdx4   = wbAdrI[3:2];
  wire         selFpData = (wbAdrI[7:5] == `RSFP_FPDATA_BASE_HI);
  wire         selMedia  = (wbAdrI[7:5] == `RSFP_MEDIA_BASE_HI);
  wire         selRange  = (wbAdrI[7:4] == `RSFP_RANGE_BASE_HI);
  wire         wrCtl     = busWr & (wbAdrI == `RSFP_ADR_CTRL);
  wire         wrMtDef   = busWr & (wbAdrI == `RSFP_ADR_MT_DEF);
  wire         wrExt     = busWr & (wbAdrI == `RSFP_ADR_EXT_FEAT);
  wire         wrFpCw    = busWr & (wbAdrI == `RSFP_ADR_FP_CW);
  wire         wrFpSw    = busWr & (wbAdrI == `RSFP_ADR_FP_SW);
  wire         wrFpTw    = busWr & (wbAdrI == `RSFP_ADR_FP_TW);
  wire         wrWmCs    = busWr & (wbAdrI == `RSFP_ADR_WM_CS);
  wire [31:0]  mergedCtl = mergeSel({25'h0, ctrl_r}, wbDatI, wbSelI);
  wire [31:0]  mergedMt  = mergeSel({20'h0, memDef_r}, wbDatI, wbSelI);
  wire [31:0]  mergedExt = mergeSel({31'h0, fastCallEn_r}, wbDatI, wbSelI);
  wire [31:0]  mergedCw  = mergeSel({16'h0, fpCw_r}, wbDatI, wbSelI);
  wire [31:0]  mergedSw  = mergeSel({16'h0, fpSw_r}, wbDatI, wbSelI);
  wire [31:0]  mergedTw  = mergeSel({16'h0, fpTw_r}, wbDatI, wbSelI);
  wire [31:0]  mergedWm  = mergeSel({16'h0, wmCs_r}, wbDatI, wbSelI);

  // Instruction side.
  wire rsfp_fault_t instrFault = faultFor(instrOp, ctrl_r, fastCallEn_r);
  wire         instrOk    = instrValid & (instrFault == RSFP_FLT_NONE);
  wire         fpClearNow = instrOk & (instrOp == RSFP_OP_FP_CLEAR);
  wire         modelWrNow = instrOk & (instrOp == RSFP_OP_MODEL_WRITE);

  // SIMD exceptions that survive their mask bits.
  wire [`RSFP_WM_FLAG_W-1:0] simdUnmasked =
    simdExcFlags & ~wmCs_r[`RSFP_WM_MASK_HI:`RSFP_WM_MASK_LO];
  wire         simdRaise = simdExcIn & (|simdUnmasked);

  wire [31:0]  idValue = {4'h0, EXT_FAMILY, EXT_MODEL, 4'h0, FAMILY, MODEL, STEPPING};

  // Identity word is reloaded by either reset input.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst || softRestart)
      resetIdWord <= idValue;
  end

  // Soft restart returns the control bits to their defaults but keeps the
  // cache-off bit, since caches are only touched by a hard reset.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      ctrl_r <= `RSFP_CTL_RST;
    else if (softRestart)
      ctrl_r <= (`RSFP_CTL_RST & ~`RSFP_CTL_KEEP_SOFT) |
                (ctrl_r & `RSFP_CTL_KEEP_SOFT);
    else if (wrCtl)
      ctrl_r <= mergedCtl[`RSFP_CTL_W-1:0];
  end

  // Invalidate is held through hard reset and drops at the first edge after.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      cacheInvalidate <= 1'b1;
      cacheEnable     <= 1'b0;
    end
    else
    begin
      cacheInvalidate <= 1'b0;
      cacheEnable     <= ~ctrl_r[`RSFP_CTL_CACHE_OFF];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      memDef_r <= `RSFP_MT_DEF_RST;
    else if (wrMtDef)
      memDef_r <= mergedMt[`RSFP_MT_DEF_W-1:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      memTypeEnable <= 1'b0;
    else
      memTypeEnable <= memDef_r[`RSFP_MT_DEF_EN];
  end

  // Range registers carry no reset; software must load them first.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_range
      always_ff @(posedge clk_sys)
      begin
        if (busWr && selRange && adrIdx4 == gi)
          memRange_r[gi] <= mergeSel(memRange_r[gi], wbDatI, wbSelI);
      end

      // Model registers likewise start undefined; only instructions reach them.
      always_ff @(posedge clk_sys)
      begin
        if (modelWrNow && instrIdx == gi)
          modelReg_r[gi] <= instrData;
      end
    end
  endgenerate

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      fastCallEn_r <= 1'b0;
    else if (wrExt)
      fastCallEn_r <= mergedExt[`RSFP_EXT_FASTCALL];
  end

  // x87 words: soft restart has no branch here, so the state is kept.
  // The clear instruction wins over a bus write in the same cycle.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      fpCw_r <= `RSFP_FP_CW_RST;
      fpSw_r <= `RSFP_FP_SW_RST;
      fpTw_r <= `RSFP_FP_TW_RST;
    end
    else
    begin
      if (fpClearNow)
        fpCw_r <= `RSFP_FP_CW_CLEAR;
      else if (wrFpCw)
        fpCw_r <= mergedCw[15:0];
      if (fpClearNow)
        fpTw_r <= `RSFP_FP_TW_CLEAR;
      else if (wrFpTw)
        fpTw_r <= mergedTw[15:0];
      if (wrFpSw)
        fpSw_r <= mergedSw[15:0];
    end
  end

  // Data and 64-bit media registers: zeroed by hard reset only, and neither
  // is written by the clear instruction.
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_fpmedia
      always_ff @(posedge clk_sys)
      begin
        if (!nrst)
          fpData_r[gi] <= 32'h0;
        else if (busWr && selFpData && adrIdx8 == gi)
          fpData_r[gi] <= mergeSel(fpData_r[gi], wbDatI, wbSelI);
      end

      always_ff @(posedge clk_sys)
      begin
        if (!nrst)
          media_r[gi] <= 32'h0;
        else if (busWr && selMedia && adrIdx8 == gi)
          media_r[gi] <= mergeSel(media_r[gi], wbDatI, wbSelI);
      end
    end
  endgenerate

  // Raised flags are OR-ed in after the bus write so a new event is never
  // lost to a clear in the same cycle.
  assign wmCs_nxt = (wrWmCs ? mergedWm[15:0] : wmCs_r) |
                    {10'h0, simdExcIn ? simdExcFlags : 6'h00};

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      wmCs_r <= `RSFP_WM_CS_RST;
    else
      wmCs_r <= wmCs_nxt;
  end

  // One-cycle answer to each issued instruction.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      respValid <= 1'b0;
      respFault <= RSFP_FLT_NONE;
      respData  <= 32'h0;
    end
    else
    begin
      respValid <= instrValid;
      respFault <= instrValid ? instrFault : RSFP_FLT_NONE;
      respData  <= (instrOk && instrOp == RSFP_OP_MODEL_READ) ?
                   modelReg_r[instrIdx] : 32'h0;
    end
  end

  // Exception delivery. An x87 exception goes either to the pending fault or
  // to the external pin; a SIMD one to its own fault or to the bad opcode.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      excFaultValid <= 1'b0;
      excFault      <= RSFP_FLT_NONE;
      fpErrorExt    <= 1'b0;
    end
    else
    begin
      fpErrorExt    <= x87ExcIn & ~ctrl_r[`RSFP_CTL_INT_FAULT];
      excFaultValid <= (x87ExcIn & ctrl_r[`RSFP_CTL_INT_FAULT]) | simdRaise;
      if (x87ExcIn && ctrl_r[`RSFP_CTL_INT_FAULT])
        excFault <= RSFP_FLT_FP_PENDING;
      else if (simdRaise)
        excFault <= ctrl_r[`RSFP_CTL_WM_FAULT] ?
                    RSFP_FLT_SIMD_FP : RSFP_FLT_BAD_OPCODE;
      else
        excFault <= RSFP_FLT_NONE;
    end
  end

  always_comb
  begin
    rdData = 32'h0;
    if (selFpData)
      rdData = fpData_r[adrIdx8];
    else if (selMedia)
      rdData = media_r[adrIdx8];
    else if (selRange)
      rdData = memRange_r[adrIdx4];
    else
    begin
      case (wbAdrI)
        `RSFP_ADR_ID:       rdData = resetIdWord;
        `RSFP_ADR_CTRL:     rdData = {25'h0, ctrl_r};
        `RSFP_ADR_MT_DEF:   rdData = {20'h0, memDef_r};
        `RSFP_ADR_EXT_FEAT: rdData = {31'h0, fastCallEn_r};
        `RSFP_ADR_FP_CW:    rdData = {16'h0, fpCw_r};
        `RSFP_ADR_FP_SW:    rdData = {16'h0, fpSw_r};
        `RSFP_ADR_FP_TW:    rdData = {16'h0, fpTw_r};
        `RSFP_ADR_WM_CS:    rdData = {16'h0, wmCs_r};
        default:            rdData = 32'h0;
      endcase
    end
  end

  // Every request, mapped or not, is acknowledged one cycle after it is seen.
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      wbAckO <= 1'b0;
      wbDatO <= 32'h0;
    end
    else
    begin
      wbAckO <= busReq;
      wbDatO <= busReq ? rdData : 32'h0;
    end
  end

endmodule

// ===== testbench/rsfp_reset_ctl_sva.sv
/*
  Concurrent checks on the ports of the reset-state and enable block.
  Assumes one clock domain and the synchronous active-low hard reset.
*/
`timescale 1ns/1ps
module rsfp_reset_ctl_sva
  import rsfp_pkg::*;
#(
  parameter logic [3:0] STEPPING   = 4'h1,
  parameter logic [3:0] MODEL      = 4'h2,
  parameter logic [3:0] FAMILY     = 4'h3,
  parameter logic [3:0] EXT_MODEL  = 4'h0,
  parameter logic [7:0] EXT_FAMILY = 8'h00
)
(
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        softRestart,
  input wire logic        wbCycI,
  input wire logic        wbStbI,
  input wire logic        wbAckO,
  input wire logic        instrValid,
  input rsfp_op_t         instrOp,
  input wire logic        respValid,
  input rsfp_fault_t      respFault,
  input wire logic        x87ExcIn,
  input wire logic        simdExcIn,
  input wire logic        excFaultValid,
  input rsfp_fault_t      excFault,
  input wire logic        fpErrorExt,
  input wire logic [31:0] resetIdWord,
  input wire logic        cacheEnable,
  input wire logic        cacheInvalidate,
  input wire logic        memTypeEnable
);
  default clocking cb @(posedge clk_sys); endclocking
  wire logic [31:0] idWord = {4'h0, EXT_FAMILY, EXT_MODEL, 4'h0, FAMILY, MODEL, STEPPING};

  // Reset checks cannot be disabled by the reset they watch.
  chk_id_after_reset: assert property (!nrst |=> resetIdWord == idWord)
    else $error("identity word wrong after hard reset");
  chk_soft_keeps_cache: assert property (disable iff (!nrst)
    softRestart |=> !cacheInvalidate && resetIdWord == idWord)
    else $error("soft restart touched cache state or identity");
  chk_cache_off_rst: assert property (!nrst |=> cacheInvalidate && !cacheEnable)
    else $error("caches not disabled and invalidated in hard reset");
  chk_inval_release: assert property (disable iff (!nrst)
    nrst && $past(!nrst) |=> !cacheInvalidate)
    else $error("invalidate not released after reset");
  chk_memtype_rst: assert property (!nrst |=> !memTypeEnable)
    else $error("memory typing on after hard reset");
  chk_ack_pulse: assert property (disable iff (!nrst)
    wbCycI && wbStbI && !wbAckO |=> wbAckO ##1 !wbAckO)
    else $error("bus ack not a single pulse one cycle after request");
  chk_model_no_fault: assert property (disable iff (!nrst) instrValid &&
    (instrOp == RSFP_OP_MODEL_READ || instrOp == RSFP_OP_MODEL_WRITE)
    |=> respValid && respFault == RSFP_FLT_NONE)
    else $error("model register access faulted");
  chk_resp_quiet: assert property (disable iff (!nrst)
    !instrValid |=> !respValid && respFault == RSFP_FLT_NONE)
    else $error("response without instruction");
  chk_x87_delivery: assert property (disable iff (!nrst)
    x87ExcIn |=> fpErrorExt || (excFaultValid && excFault == RSFP_FLT_FP_PENDING))
    else $error("x87 exception not delivered");
  chk_err_cause: assert property (disable iff (!nrst)
    fpErrorExt |-> $past(x87ExcIn))
    else $error("external error without x87 exception");
  chk_fault_cause: assert property (disable iff (!nrst)
    excFaultValid |-> $past(x87ExcIn) || $past(simdExcIn))
    else $error("exception fault without event");
endmodule

bind rsfp_reset_ctl rsfp_reset_ctl_sva #(.STEPPING(STEPPING), .MODEL(MODEL), .FAMILY(FAMILY),
  .EXT_MODEL(EXT_MODEL), .EXT_FAMILY(EXT_FAMILY)) rsfp_reset_ctl_sva_inst (
  .clk_sys(clk_sys), .nrst(nrst), .softRestart(softRestart), .wbCycI(wbCycI),
  .wbStbI(wbStbI), .wbAckO(wbAckO), .instrValid(instrValid), .instrOp(instrOp),
  .respValid(respValid), .respFault(respFault), .x87ExcIn(x87ExcIn),
  .simdExcIn(simdExcIn), .excFaultValid(excFaultValid), .excFault(excFault),
  .fpErrorExt(fpErrorExt), .resetIdWord(resetIdWord), .cacheEnable(cacheEnable),
  .cacheInvalidate(cacheInvalidate), .memTypeEnable(memTypeEnable));

// ===== testbench/test_rsfp_reset_ctl.sv
/*
  Self-checking bench for the reset-state and enable block.
  Assumes the checker is bound in and a classic Wishbone master on the bus.
*/
`timescale 1ns/1ps
`include "rsfp_defines.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module test_rsfp_reset_ctl
  import rsfp_pkg::*;
;
  // Identity fields are arbitrary values.
  localparam logic [31:0] ID = 32'h0098_0765;
  logic clk_sys = 1'b0, nrst = 1'b0, softRestart = 1'b0;
  logic wbCycI = 1'b0, wbStbI = 1'b0, wbWeI = 1'b0, instrValid = 1'b0;
  logic [7:0] wbAdrI = 8'h00;
  logic [3:0] wbSelI = 4'hf;
  logic [31:0] wbDatI = 32'h0, instrData = 32'h0, wbDatO, respData, resetIdWord, rd;
  rsfp_op_t instrOp = RSFP_OP_X87;
  logic [1:0] instrIdx = 2'h0;
  logic x87ExcIn = 1'b0, simdExcIn = 1'b0, wbAckO, respValid, excFaultValid, fpErrorExt;
  logic [5:0] simdExcFlags = 6'h00;
  logic cacheEnable, cacheInvalidate, memTypeEnable, eV, eE;
  rsfp_fault_t respFault, excFault, f, eF;
  int error_cnt = 0, total_checks = 0;

  rsfp_reset_ctl #(.STEPPING(4'h5), .MODEL(4'h6), .FAMILY(4'h7), .EXT_MODEL(4'h8),
    .EXT_FAMILY(8'h09)) rsfp_reset_ctl_inst (
    .clk_sys(clk_sys), .nrst(nrst), .softRestart(softRestart), .wbCycI(wbCycI),
    .wbStbI(wbStbI), .wbWeI(wbWeI), .wbAdrI(wbAdrI), .wbSelI(wbSelI), .wbDatI(wbDatI),
    .wbDatO(wbDatO), .wbAckO(wbAckO), .instrValid(instrValid), .instrOp(instrOp),
    .instrIdx(instrIdx), .instrData(instrData), .respValid(respValid),
    .respFault(respFault), .respData(respData), .x87ExcIn(x87ExcIn),
    .simdExcIn(simdExcIn), .simdExcFlags(simdExcFlags), .excFaultValid(excFaultValid),
    .excFault(excFault), .fpErrorExt(fpErrorExt), .resetIdWord(resetIdWord),
    .cacheEnable(cacheEnable), .cacheInvalidate(cacheInvalidate),
    .memTypeEnable(memTypeEnable));

  initial forever #50 clk_sys = ~clk_sys;

  task conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    wbCycI <= 1'b1; wbStbI <= 1'b1; wbWeI <= we; wbAdrI <= a; wbDatI <= d;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk_sys);
      if (wbAckO === 1'b1) break;
    end
    rd = wbDatO;
    wbCycI <= 1'b0; wbStbI <= 1'b0;
    if (n == 20)
    begin
      error_cnt++;
      conclude();
    end
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    `CHK(rd, exp)
  endtask

  task op(input rsfp_op_t o, input logic [1:0] i, input logic [31:0] d);
    @(posedge clk_sys);
    instrValid <= 1'b1; instrOp <= o; instrIdx <= i; instrData <= d;
    @(posedge clk_sys);
    instrValid <= 1'b0;
    #1;
    `CHK(respValid, 1'b1)
    f = respFault;
  endtask

  task exc(input logic x, input logic s, input logic [5:0] fl);
    @(posedge clk_sys);
    x87ExcIn <= x; simdExcIn <= s; simdExcFlags <= fl;
    @(posedge clk_sys);
    x87ExcIn <= 1'b0; simdExcIn <= 1'b0;
    #1;
    eV = excFaultValid; eF = excFault; eE = fpErrorExt;
  endtask

  task hard_reset();
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
  endtask

  task test_reset_values();
    `CHK(resetIdWord, ID)
    `CHK(cacheEnable, 1'b0)
    `CHK(memTypeEnable, 1'b0)
    rdchk(`RSFP_ADR_ID, ID);
    rdchk(`RSFP_ADR_CTRL, 32'h1);
    rdchk(`RSFP_ADR_MT_DEF, 32'h0);
    rdchk(`RSFP_ADR_EXT_FEAT, 32'h0);
    rdchk(`RSFP_ADR_FP_CW, 32'h40);
    rdchk(`RSFP_ADR_FP_SW, 32'h0);
    rdchk(`RSFP_ADR_FP_TW, 32'h5555);
    rdchk(8'h5c, 32'h0);
    rdchk(8'h60, 32'h0);
    rdchk(`RSFP_ADR_WM_CS, 32'h1f80);
    rdchk(8'hfc, 32'h0);
    $display("test_reset_values done");
  endtask

  task test_cache_memtype();
    int i;
    for (i = 0; i < 4; i++)
      wb(1'b1, 8'h10 + 8'(4 * i), 32'h0);
    wb(1'b1, `RSFP_ADR_CTRL, 32'h0);
    wb(1'b1, `RSFP_ADR_MT_DEF, 32'h800);
    wb(1'b1, `RSFP_ADR_ID, 32'hffff_ffff);
    wb(1'b1, 8'hfc, 32'hffff_ffff);
    repeat (2) @(posedge clk_sys);
    #1;
    `CHK(cacheEnable, 1'b1)
    `CHK(memTypeEnable, 1'b1)
    rdchk(`RSFP_ADR_ID, ID);
    $display("test_cache_memtype done");
  endtask

  task fault_case(input logic [31:0] c, input logic [31:0] e, input rsfp_op_t o,
                  input rsfp_fault_t x);
    wb(1'b1, `RSFP_ADR_CTRL, c);
    wb(1'b1, `RSFP_ADR_EXT_FEAT, e);
    op(o, 2'h0, 32'h0);
    `CHK(f, x)
  endtask

  task test_faults();
    fault_case(32'h00, 32'h0, RSFP_OP_X87, RSFP_FLT_NONE);
    fault_case(32'h04, 32'h0, RSFP_OP_X87, RSFP_FLT_FP_UNAVAIL);
    fault_case(32'h04, 32'h0, RSFP_OP_FP_CLEAR, RSFP_FLT_FP_UNAVAIL);
    rdchk(`RSFP_ADR_FP_CW, 32'h40);
    fault_case(32'h12, 32'h0, RSFP_OP_FP_SYNC, RSFP_FLT_FP_UNAVAIL);
    fault_case(32'h02, 32'h0, RSFP_OP_FP_SYNC, RSFP_FLT_NONE);
    fault_case(32'h00, 32'h0, RSFP_OP_MEDIA64, RSFP_FLT_NONE);
    fault_case(32'h04, 32'h0, RSFP_OP_MEDIA64, RSFP_FLT_BAD_OPCODE);
    fault_case(32'h24, 32'h0, RSFP_OP_MEDIA128, RSFP_FLT_BAD_OPCODE);
    fault_case(32'h00, 32'h0, RSFP_OP_MEDIA128, RSFP_FLT_BAD_OPCODE);
    fault_case(32'h20, 32'h0, RSFP_OP_MEDIA128, RSFP_FLT_NONE);
    fault_case(32'h00, 32'h0, RSFP_OP_FAST_CALL, RSFP_FLT_BAD_OPCODE);
    fault_case(32'h00, 32'h1, RSFP_OP_FAST_CALL, RSFP_FLT_NONE);
    $display("test_faults done");
  endtask

  task test_fp_clear();
    wb(1'b1, 8'h44, 32'h1234);
    wb(1'b1, 8'h64, 32'h5678);
    op(RSFP_OP_FP_CLEAR, 2'h0, 32'h0);
    `CHK(f, RSFP_FLT_NONE)
    rdchk(`RSFP_ADR_FP_CW, 32'h37f);
    rdchk(`RSFP_ADR_FP_TW, 32'hffff);
    rdchk(8'h44, 32'h1234);
    rdchk(8'h64, 32'h5678);
    op(RSFP_OP_MODEL_WRITE, 2'h2, 32'hcafe_0001);
    op(RSFP_OP_MODEL_READ, 2'h2, 32'h0);
    `CHK(respData, 32'hcafe_0001)
    $display("test_fp_clear done");
  endtask

  task test_exceptions();
    wb(1'b1, `RSFP_ADR_CTRL, 32'h08);
    exc(1'b1, 1'b0, 6'h00);
    `CHK({eV, eF, eE}, {1'b1, RSFP_FLT_FP_PENDING, 1'b0})
    wb(1'b1, `RSFP_ADR_CTRL, 32'h40);
    exc(1'b1, 1'b0, 6'h00);
    `CHK({eV, eE}, 2'b01)
    wb(1'b1, `RSFP_ADR_WM_CS, 32'h0);
    exc(1'b0, 1'b1, 6'h01);
    `CHK({eV, eF}, {1'b1, RSFP_FLT_SIMD_FP})
    rdchk(`RSFP_ADR_WM_CS, 32'h1);
    wb(1'b1, `RSFP_ADR_CTRL, 32'h0);
    exc(1'b0, 1'b1, 6'h02);
    `CHK({eV, eF}, {1'b1, RSFP_FLT_BAD_OPCODE})
    wb(1'b1, `RSFP_ADR_WM_CS, 32'h1f80);
    exc(1'b0, 1'b1, 6'h3f);
    `CHK(eV, 1'b0)
    $display("test_exceptions done");
  endtask

  task test_restarts();
    wb(1'b1, `RSFP_ADR_CTRL, 32'h7e);
    wb(1'b1, `RSFP_ADR_FP_CW, 32'h123);
    // Only byte lane 1 is enabled, so the status word takes just that byte.
    wbSelI <= 4'h2;
    wb(1'b1, `RSFP_ADR_FP_SW, 32'haaaa_bbcc);
    wbSelI <= 4'hf;
    @(posedge clk_sys);
    softRestart <= 1'b1;
    @(posedge clk_sys);
    softRestart <= 1'b0;
    rdchk(`RSFP_ADR_CTRL, 32'h0);
    rdchk(`RSFP_ADR_FP_CW, 32'h123);
    rdchk(`RSFP_ADR_FP_SW, 32'hbb00);
    rdchk(8'h64, 32'h5678);
    rdchk(`RSFP_ADR_MT_DEF, 32'h800);
    #1;
    `CHK(cacheEnable, 1'b1)
    `CHK(resetIdWord, ID)
    hard_reset();
    rdchk(`RSFP_ADR_CTRL, 32'h1);
    rdchk(`RSFP_ADR_FP_CW, 32'h40);
    rdchk(`RSFP_ADR_FP_SW, 32'h0);
    rdchk(8'h44, 32'h0);
    rdchk(8'h64, 32'h0);
    rdchk(`RSFP_ADR_MT_DEF, 32'h0);
    $display("test_restarts done");
  endtask

  initial
  begin
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    #1;
    test_reset_values();
    test_cache_memtype();
    test_faults();
    test_fp_clear();
    test_exceptions();
    test_restarts();
    conclude();
  end
endmodule
